// ### rtl/tmci_edge_detect.sv
// capture pin edge detector with selectable edge
`timescale 1ns/1ps
module tmci_edge_detect
	import tmci_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// pin and selection
	input  wire logic       pin,
	input  wire logic [1:0] sel,
	input  wire logic       arm,
	// result
	output logic            hit
);
	tmci_edge_t s;
	tmci_edge_t next_s;
	logic       rise;
	logic       fall;

	always_comb
	begin
		next_s = s;
		next_s.prev = pin;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign rise = pin && !s.prev;
	assign fall = !pin && s.prev;
	// the reserved selection matches nothing
	assign hit = arm && (((sel == TMCI_EDGE_RISE) && rise) ||
		((sel == TMCI_EDGE_FALL) && fall) ||
		((sel == TMCI_EDGE_BOTH) && (rise || fall)));

	property p_edge_rise;
		@(posedge aclk) disable iff (!aresetn)
		(arm && sel == TMCI_EDGE_RISE && !$past(pin) && pin) |-> hit;
	endproperty
	a_edge_rise: assert property (p_edge_rise)
		else $error("rising edge not detected");

	property p_edge_reserved;
		@(posedge aclk) disable iff (!aresetn)
		(sel == 2'h2) |-> !hit;
	endproperty
	a_edge_reserved: assert property (p_edge_reserved)
		else $error("reserved edge selection produced a hit");
endmodule

// ### rtl/tmci_pkg.sv
// constants, types and helpers of the timer mode, control and irq block
package tmci_pkg;

	// register byte offsets
	localparam logic [7:0] TMCI_OFS_CFG    = 8'h00;
	localparam logic [7:0] TMCI_OFS_MODE_A = 8'h04;
	localparam logic [7:0] TMCI_OFS_MODE_B = 8'h08;
	localparam logic [7:0] TMCI_OFS_CTL    = 8'h0C;
	localparam logic [7:0] TMCI_OFS_MASK   = 8'h18;
	localparam logic [7:0] TMCI_OFS_RAW    = 8'h1C;
	localparam logic [7:0] TMCI_OFS_MIS    = 8'h20;
	localparam logic [7:0] TMCI_OFS_CLR    = 8'h24;

	// width configuration values
	localparam logic [2:0] TMCI_CFG_32BIT = 3'h0;
	localparam logic [2:0] TMCI_CFG_RTC   = 3'h1;
	localparam logic [2:0] TMCI_CFG_16BIT = 3'h4;

	// mode register fields
	localparam int         TMCI_MODE_ALT  = 3;
	localparam int         TMCI_MODE_CMR  = 2;
	localparam logic [1:0] TMCI_MD_ONE    = 2'h1;
	localparam logic [1:0] TMCI_MD_PER    = 2'h2;
	localparam logic [1:0] TMCI_MD_CAP    = 2'h3;

	// control register fields, half b sits one stride above half a
	localparam int          TMCI_HALF_STRIDE = 8;
	localparam int          TMCI_CTL_EN      = 0;
	localparam int          TMCI_CTL_STALL   = 1;
	localparam int          TMCI_CTL_EVT     = 2;
	localparam int          TMCI_CTL_CLOCK_COUNT_ENABLE   = 4;
	localparam int          TMCI_CTL_OTE     = 5;
	localparam int          TMCI_CTL_INV     = 6;
	localparam logic [14:0] TMCI_CTL_WMASK   = 15'h6F7F;

	// capture edge selection
	localparam logic [1:0] TMCI_EDGE_RISE = 2'h0;
	localparam logic [1:0] TMCI_EDGE_FALL = 2'h1;
	localparam logic [1:0] TMCI_EDGE_BOTH = 2'h3;

	// interrupt bit positions, mask and raw share the layout
	localparam int          TMCI_IRQ_TO    = 0;
	localparam int          TMCI_IRQ_MATCH = 1;
	localparam int          TMCI_IRQ_EV    = 2;
	localparam int          TMCI_IRQ_RTC   = 3;
	localparam logic [10:0] TMCI_IRQ_VALID = 11'h70F;

	localparam logic [1:0] TMCI_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TMCI_RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {TMCI_W_IDLE = 1'b0, TMCI_W_RESP = 1'b1} tmci_wst_t;
	typedef enum logic [0:0] {TMCI_R_IDLE = 1'b0, TMCI_R_DATA = 1'b1} tmci_rst_t;

	typedef struct packed {
		logic [2:0]       cfg;
		logic [1:0][3:0]  mode;
		logic [14:0]      ctl;
		logic [10:0]      mask;
		logic [10:0]      raw;
		logic             aw_have;
		logic [7:0]       aw_addr;
		logic             w_have;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             awready;
		logic             wready;
		tmci_wst_t        wst;
		logic [1:0]       bresp;
		logic             arready;
		tmci_rst_t        rst;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic [1:0]       run;
		logic [1:0]       one_shot;
		logic [1:0]       periodic;
		logic [1:0]       edge_count;
		logic [1:0]       edge_time;
		logic [1:0]       pwm_mode;
		logic [1:0]       edge_pulse;
		logic [1:0]       pwm_out;
		logic [1:0]       trig_out;
		logic             wide;
		logic             rtc_run;
		logic             irq;
	} tmci_state_t;

	localparam tmci_state_t TMCI_STATE_RST = '0;

	typedef struct packed {
		logic prev;
	} tmci_edge_t;

	function automatic logic [31:0] tmci_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction

endpackage

// ### rtl/tmci_top.sv
// mode, control and interrupt logic of a dual 16-bit timer, axi4-lite slave
`timescale 1ns/1ps
module tmci_top
	import tmci_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// events from the counter datapath, index 0 half a, 1 half b
	input  wire logic [1:0]  timeout_in,
	input  wire logic [1:0]  match_in,
	input  wire logic        rtc_event_in,
	input  wire logic        debug_halt,
	// pins
	input  wire logic [1:0]  capture_pin,
	input  wire logic [1:0]  pwm_raw,
	output logic [1:0]       pwm_out,
	output logic [1:0]       trigger_out,
	// controls toward the counter datapath
	output logic [1:0]       half_run,
	output logic [1:0]       half_one_shot,
	output logic [1:0]       half_periodic,
	output logic [1:0]       half_edge_count,
	output logic [1:0]       half_edge_time,
	output logic [1:0]       half_pwm,
	output logic [1:0]       edge_pulse,
	output logic             wide_mode,
	output logic             rtc_run,
	// interrupt
	output logic             irq
);
	tmci_state_t s;
	tmci_state_t next_s;

	logic [1:0]  active;
	logic [1:0]  is_cap;
	logic [1:0]  is_one;
	logic [1:0]  is_per;
	logic [1:0]  is_pwm;
	logic [1:0]  hit;
	logic        wide_cfg;
	logic        wr_fire;
	logic [7:0]  wa;
	logic [32:0] wcur;
	logic [32:0] rcur;
	logic [31:0] wv;
	logic [10:0] clr;
	logic [10:0] set;

	// bit 32 flags a mapped offset
	function automatic logic [32:0] tmci_rd(input tmci_state_t st,
		input logic [7:0] a);
		logic [7:0] al;
		al = {a[7:2], 2'b00};
		if (al == TMCI_OFS_CFG)
			return {1'b1, 29'h0, st.cfg};
		else if (al == TMCI_OFS_MODE_A)
			return {1'b1, 28'h0, st.mode[0]};
		else if (al == TMCI_OFS_MODE_B)
			return {1'b1, 28'h0, st.mode[1]};
		else if (al == TMCI_OFS_CTL)
			return {1'b1, 17'h0, st.ctl};
		else if (al == TMCI_OFS_MASK)
			return {1'b1, 21'h0, st.mask};
		else if (al == TMCI_OFS_RAW)
			return {1'b1, 21'h0, st.raw};
		else if (al == TMCI_OFS_MIS)
			return {1'b1, 21'h0, st.raw & st.mask};
		else if (al == TMCI_OFS_CLR)
			return {1'b1, 32'h0};
		else
			return {1'b0, 32'h0};
	endfunction

	assign wide_cfg = (s.cfg != TMCI_CFG_16BIT);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_half
			localparam int B = g * TMCI_HALF_STRIDE;
			// in a wide setting half b idles and half a runs the pair
			assign active[g] = s.ctl[B + TMCI_CTL_EN] &&
				((g == 0) || !wide_cfg);
			assign is_cap[g] = !s.mode[g][TMCI_MODE_ALT] &&
				(s.mode[g][1:0] == TMCI_MD_CAP);
			assign is_one[g] = !s.mode[g][TMCI_MODE_ALT] &&
				(s.mode[g][1:0] == TMCI_MD_ONE);
			assign is_per[g] = !s.mode[g][TMCI_MODE_ALT] &&
				(s.mode[g][1:0] == TMCI_MD_PER);
			assign is_pwm[g] = s.mode[g][TMCI_MODE_ALT] &&
				(s.mode[g][1:0] == TMCI_MD_PER);
			tmci_edge_detect u_edge (
				.aclk    (aclk),
				.aresetn (aresetn),
				.pin     (capture_pin[g]),
				.sel     (s.ctl[B + TMCI_CTL_EVT +: 2]),
				.arm     (active[g] && is_cap[g]),
				.hit     (hit[g])
			);
		end
	endgenerate

	always_comb
	begin
		next_s = s;
		wr_fire = 1'b0;
		wa = 8'h00;
		wcur = '0;
		rcur = '0;
		wv = 32'h0;
		clr = 11'h0;
		set = 11'h0;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s.awready)
		begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.w_have = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.wst == TMCI_W_RESP && s_axi_bready)
			next_s.wst = TMCI_W_IDLE;
		wr_fire = next_s.aw_have && next_s.w_have &&
			(next_s.wst == TMCI_W_IDLE);
		if (wr_fire)
		begin
			wa = {next_s.aw_addr[7:2], 2'b00};
			wcur = tmci_rd(s, wa);
			wv = tmci_merge(wcur[31:0], next_s.wdata, next_s.wstrb);
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.wst = TMCI_W_RESP;
			next_s.bresp = wcur[32] ? TMCI_RESP_OKAY : TMCI_RESP_SLVERR;
			if (wa == TMCI_OFS_CFG)
				next_s.cfg = wv[2:0];
			else if (wa == TMCI_OFS_MODE_A)
				next_s.mode[0] = wv[3:0];
			else if (wa == TMCI_OFS_MODE_B)
				next_s.mode[1] = wv[3:0];
			else if (wa == TMCI_OFS_CTL)
				next_s.ctl = wv[14:0] & TMCI_CTL_WMASK;
			else if (wa == TMCI_OFS_MASK)
				next_s.mask = wv[10:0] & TMCI_IRQ_VALID;
			else if (wa == TMCI_OFS_CLR)
				clr = wv[10:0] & TMCI_IRQ_VALID;
		end
		next_s.awready = !next_s.aw_have && (next_s.wst == TMCI_W_IDLE);
		next_s.wready = !next_s.w_have && (next_s.wst == TMCI_W_IDLE);

		// read channel
		if (s.rst == TMCI_R_DATA && s_axi_rready)
			next_s.rst = TMCI_R_IDLE;
		if (s_axi_arvalid && s.arready)
		begin
			rcur = tmci_rd(s, s_axi_araddr);
			next_s.rst = TMCI_R_DATA;
			next_s.rdata = rcur[31:0];
			next_s.rresp = rcur[32] ? TMCI_RESP_OKAY : TMCI_RESP_SLVERR;
		end
		next_s.arready = (next_s.rst == TMCI_R_IDLE);

		// per-half decode and events
		for (int h = 0; h < 2; h++)
		begin
			next_s.run[h] = active[h] && !(debug_halt &&
				s.ctl[h*TMCI_HALF_STRIDE + TMCI_CTL_STALL]);
			next_s.one_shot[h] = is_one[h];
			next_s.periodic[h] = is_per[h];
			next_s.edge_count[h] = is_cap[h] &&
				!s.mode[h][TMCI_MODE_CMR];
			next_s.edge_time[h] = is_cap[h] &&
				s.mode[h][TMCI_MODE_CMR];
			next_s.pwm_mode[h] = is_pwm[h];
			next_s.edge_pulse[h] = hit[h];
			next_s.pwm_out[h] = pwm_raw[h] ^
				s.ctl[h*TMCI_HALF_STRIDE + TMCI_CTL_INV];
			next_s.trig_out[h] = timeout_in[h] && active[h] &&
				s.ctl[h*TMCI_HALF_STRIDE + TMCI_CTL_OTE];
			set[h*TMCI_HALF_STRIDE + TMCI_IRQ_TO] =
				timeout_in[h] && active[h] && !is_cap[h];
			set[h*TMCI_HALF_STRIDE + TMCI_IRQ_MATCH] =
				match_in[h] && active[h] && next_s.edge_count[h];
			set[h*TMCI_HALF_STRIDE + TMCI_IRQ_EV] =
				hit[h] && next_s.edge_time[h];
			// a one-shot or finished edge count drops its own enable
			if ((timeout_in[h] && active[h] && is_one[h]) ||
				set[h*TMCI_HALF_STRIDE + TMCI_IRQ_MATCH])
				next_s.ctl[h*TMCI_HALF_STRIDE + TMCI_CTL_EN] = 1'b0;
		end
		next_s.wide = wide_cfg;
		next_s.rtc_run = s.ctl[TMCI_CTL_CLOCK_COUNT_ENABLE] && active[0] &&
			(s.cfg == TMCI_CFG_RTC);
		set[TMCI_IRQ_RTC] = rtc_event_in && s.ctl[TMCI_CTL_CLOCK_COUNT_ENABLE];

		// a set in the cycle of its clear wins
		next_s.raw = (s.raw & ~clr) | set;
		next_s.irq = |(next_s.raw & next_s.mask);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= TMCI_STATE_RST;
		else
			s <= next_s;
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.wst;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rst;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign pwm_out = s.pwm_out;
	assign trigger_out = s.trig_out;
	assign half_run = s.run;
	assign half_one_shot = s.one_shot;
	assign half_periodic = s.periodic;
	assign half_edge_count = s.edge_count;
	assign half_edge_time = s.edge_time;
	assign half_pwm = s.pwm_mode;
	assign edge_pulse = s.edge_pulse;
	assign wide_mode = s.wide;
	assign rtc_run = s.rtc_run;
	assign irq = s.irq;

	property p_pwm_inv;
		@(posedge aclk) disable iff (!aresetn)
		s.ctl[TMCI_CTL_INV] && pwm_raw[0] |=> !pwm_out[0];
	endproperty
	a_pwm_inv: assert property (p_pwm_inv)
		else $error("pwm a not inverted");

	property p_trig_off;
		@(posedge aclk) disable iff (!aresetn)
		!s.ctl[TMCI_HALF_STRIDE + TMCI_CTL_OTE] |=> !trigger_out[1];
	endproperty
	a_trig_off: assert property (p_trig_off)
		else $error("trigger b driven while disabled");

	property p_stall;
		@(posedge aclk) disable iff (!aresetn)
		debug_halt && s.ctl[TMCI_CTL_STALL] |=> !half_run[0];
	endproperty
	a_stall: assert property (p_stall)
		else $error("half a counts while stalled");

	property p_enable;
		@(posedge aclk) disable iff (!aresetn)
		s.ctl[TMCI_CTL_EN] && !debug_halt |=> half_run[0];
	endproperty
	a_enable: assert property (p_enable)
		else $error("half a enabled but not running");

	property p_rtc;
		@(posedge aclk) disable iff (!aresetn)
		rtc_run |-> $past(s.ctl[TMCI_CTL_CLOCK_COUNT_ENABLE]);
	endproperty
	a_rtc: assert property (p_rtc)
		else $error("rtc runs without its enable");

	property p_mask_rsv;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && wa == TMCI_OFS_MASK |=> s.mask[7:4] == 4'h0;
	endproperty
	a_mask_rsv: assert property (p_mask_rsv)
		else $error("reserved mask bits written");

	property p_raw_set;
		@(posedge aclk) disable iff (!aresetn)
		timeout_in[0] && active[0] && !is_cap[0] |=> s.raw[0] ##1 1'b1;
	endproperty
	a_raw_set: assert property (p_raw_set)
		else $error("time-out raw bit not set");

	property p_clear;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && wa == TMCI_OFS_CLR && wv[TMCI_IRQ_RTC] && !rtc_event_in
			|=> !s.raw[TMCI_IRQ_RTC];
	endproperty
	a_clear: assert property (p_clear)
		else $error("raw bit survived its clear");

	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		irq |-> |(s.raw & s.mask);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq without unmasked raw bit");

	property p_one_shot;
		@(posedge aclk) disable iff (!aresetn)
		timeout_in[0] && active[0] && is_one[0] && !wr_fire
			|=> !s.ctl[TMCI_CTL_EN] ##1 !half_run[0];
	endproperty
	a_one_shot: assert property (p_one_shot)
		else $error("one-shot half a kept running");
endmodule

// ### verification/tmci_tb_top.sv
// self-checking bench of the timer mode, control and irq block
`timescale 1ns/1ps
module tmci_tb_top
	import tmci_pkg::*;
();
	logic        aclk, aresetn, rtc_event_in, debug_halt, irq;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, wide_mode, rtc_run;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, timeout_in, match_in, capture_pin;
	logic [1:0]  pwm_raw, pwm_out, trigger_out, half_run, half_one_shot;
	logic [1:0]  half_periodic, half_edge_count, half_edge_time, half_pwm;
	logic [1:0]  edge_pulse, bresp_seen, rresp_seen;
	int          err_count, checks_done, ntrig, nedge;
	// mode values and the decode each must give: one, per, cnt, time, pwm
	logic [3:0]  md [5] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'hA};
	logic [4:0]  dp [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
	logic [15:0] cv [4] = '{16'h0303, 16'h0303, 16'h0101, 16'h0000};
	logic        hv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic [1:0]  rv [4] = '{2'h3, 2'h0, 2'h3, 2'h0};
	// the reserved selection leads and must yield no capture edge at all
	logic [1:0]  es [4] = '{2'h2, TMCI_EDGE_RISE, TMCI_EDGE_FALL,
		TMCI_EDGE_BOTH};
	int          en [4] = '{0, 1, 1, 2};

	tmci_top DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .timeout_in, .match_in, .rtc_event_in, .debug_halt,
		.capture_pin, .pwm_raw, .pwm_out, .trigger_out, .half_run,
		.half_one_shot, .half_periodic, .half_edge_count, .half_edge_time,
		.half_pwm, .edge_pulse, .wide_mode, .rtc_run, .irq);

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel is released at the edge that takes it
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				aw = 1'b1;
			if (s_axi_wready === 1'b1)
				w = 1'b1;
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		bresp_seen = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		rresp_seen = s_axi_rresp;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk($sformatf("register %h", a), v, e);
	endtask

	// one-cycle event pulse, then count trigger output cycles
	task automatic ev(input int k, input logic [1:0] h);
		@(posedge aclk);
		if (k == 0)
			timeout_in <= h;
		else if (k == 1)
			match_in <= h;
		else
			rtc_event_in <= 1'b1;
		@(posedge aclk);
		timeout_in <= 2'h0;
		match_in <= 2'h0;
		rtc_event_in <= 1'b0;
		ntrig = 0;
		repeat (4)
		begin
			@(posedge aclk);
			if (trigger_out !== 2'h0)
				ntrig++;
		end
	endtask

	task automatic edg(input logic v);
		@(posedge aclk);
		capture_pin <= {v, v};
		repeat (4)
		begin
			@(posedge aclk);
			if (edge_pulse[0] === 1'b1)
				nedge++;
		end
	endtask

	task automatic tick();
		repeat (3) @(posedge aclk);
	endtask

	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		finish_test();
	end

	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, rtc_event_in, debug_halt} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot, timeout_in, match_in} = '0;
		{capture_pin, pwm_raw} = '0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (md[i])
			rc(8'(i * 4), 32'h0);
		rc(8'h1C, 32'h0);
		rd(8'h40, d);
		chk("read resp", rresp_seen, TMCI_RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk("write resp", bresp_seen, TMCI_RESP_SLVERR);
		wr(8'h18, 32'hFFFFFFFF);
		rc(8'h18, 32'h0000070F);
		wr(8'h0C, 32'hFFFFFFFF);
		rc(8'h0C, 32'h00006F7F);
		chk("wide run", half_run, 2'h1);
		wr(8'h0C, 32'h0);
		wr(8'h18, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF);
		rc(8'h1C, 32'h0);
		tend("registers");
		tick();
		chk("wide", wide_mode, 1'b1);
		wr(8'h00, 32'h4);
		tick();
		chk("wide", wide_mode, 1'b0);
		foreach (md[i])
		begin
			wr(8'h04, md[i]);
			wr(8'h08, md[i]);
			tick();
			chk("decode", {half_one_shot, half_periodic, half_edge_count,
				half_edge_time, half_pwm}, {{2{dp[i][4]}}, {2{dp[i][3]}},
				{2{dp[i][2]}}, {2{dp[i][1]}}, {2{dp[i][0]}}});
		end
		tend("mode decode");
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h2);
		foreach (cv[i])
		begin
			wr(8'h0C, cv[i]);
			debug_halt <= hv[i];
			tick();
			chk("run", half_run, rv[i]);
		end
		debug_halt <= 1'b0;
		pwm_raw <= 2'h1;
		wr(8'h0C, 32'h4040);
		tick();
		chk("pwm", pwm_out, 2'h2);
		wr(8'h0C, 32'h0);
		tick();
		chk("pwm", pwm_out, 2'h1);
		tend("control");
		wr(8'h0C, 32'h21);
		ev(0, 2'h1);
		chk("trigger", ntrig, 1);
		chk("irq", irq, 1'b0);
		rc(8'h1C, 32'h1);
		rc(8'h1C, 32'h1);
		wr(8'h18, 32'h1);
		tick();
		chk("irq", irq, 1'b1);
		wr(8'h24, 32'h0);
		rc(8'h1C, 32'h1);
		wr(8'h24, 32'h1);
		rc(8'h1C, 32'h0);
		chk("irq", irq, 1'b0);
		rc(8'h0C, 32'h21);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h0C, 32'h1);
		ev(0, 2'h1);
		chk("trigger", ntrig, 0);
		rc(8'h0C, 32'h0);
		wr(8'h0C, 32'h0100);
		ev(0, 2'h2);
		rc(8'h1C, 32'h101);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h3);
		wr(8'h0C, 32'h1);
		ev(1, 2'h1);
		rc(8'h1C, 32'h103);
		rc(8'h0C, 32'h0);
		wr(8'h24, 32'h70F);
		tend("events");
		wr(8'h04, 32'h7);
		foreach (es[i])
		begin
			wr(8'h0C, 32'h0);
			wr(8'h0C, {28'h0, es[i], 2'h1});
			nedge = 0;
			edg(1'b1);
			edg(1'b0);
			chk("edges", nedge, en[i]);
		end
		rc(8'h1C, 32'h4);
		rc(8'h0C, 32'hD);
		tend("capture");
		wr(8'h24, 32'h70F);
		wr(8'h0C, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h0C, 32'h11);
		tick();
		chk("rtc run", rtc_run, 1'b1);
		ev(2, 2'h0);
		rc(8'h1C, 32'h8);
		wr(8'h0C, 32'h1);
		tick();
		chk("rtc run", rtc_run, 1'b0);
		tend("clock count");
		// a second reset in mid-run must clear what the tests left set
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h18, 32'h0);
		rc(8'h1C, 32'h0);
		rc(8'h0C, 32'h0);
		chk("irq", irq, 1'b0);
		tend("reset");
		finish_test();
	end
endmodule
